// ==== rtl/self_filter_ctl.sv ====
// wishbone register file, self packet filter and first link control register
// How it works
// - match all, loopback, self rx: discard all
// - per mode classes accepted when loopback off
// - lower id: low 24 bits, group bit
// - hash multicast needs group bit, hash hit
// - enable bit write initialises link, buffers
// - sram cycle 100 ns or 150 ns
// - bit 5 selects host bus width
// - loopback forced, tx driver output suppressed
// - mode bits select address match detection
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module self_filter_ctl
    import self_filter_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // self-sent packet from the receiver
    input wire logic pkt_valid,
    input wire logic [47:0] pkt_dest,
    input wire logic [5:0] pkt_crc_index,
    output logic pkt_accept,
    output logic pkt_drop,
    // link and buffer control
    output logic link_init,
    output logic buf_reset,
    output logic loopback_mode,
    output logic tx_suppress,
    output logic host_bus_width,
    output logic [1:0] match_mode,
    // sram cycle timing
    output logic [SRAM_CNT_W-1:0] sram_cycle_len,
    output logic sram_slot
);
    import self_filter_pkg::*;

    // register storage
    logic [7:0] ctl_q;
    logic [1:0] mode_q;
    logic loopback_q;
    logic self_rx_q;
    logic [47:0] node_id_q;
    logic [63:0] hash_q;
    // filter outcome
    logic accept_c;
    logic accept_q;
    logic drop_q;
    logic last_accept_q;
    // bus
    logic ack_q;
    logic [31:0] rdata_q;
    logic req_c;
    logic wr_c;
    logic buf_reset_q;
    // sram slot counter
    logic [SRAM_CNT_W-1:0] sram_cnt_q;
    logic [SRAM_CNT_W-1:0] sram_len_c;
    logic slot_q;

    // byte-lane merge for a 32-bit word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // request accepted on the first cycle of a strobe
    assign req_c = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_c = req_c && wb_we_i;

    // acknowledge one cycle after the request
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req_c;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            ctl_q <= LINK_CONTROL_ONE_RESET;
        end
        else if (wr_c && wb_adr_i == OFF_LINK_CONTROL_ONE && wb_sel_i[0])
        begin
            ctl_q <= {wb_dat_i[7:5], 1'b1, wb_dat_i[3:0]};
        end
    end

    // pulse buffer reset on enable write
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            buf_reset_q <= 1'b1;
        end
        else
        begin
            buf_reset_q <= wr_c && wb_adr_i == OFF_LINK_CONTROL_ONE && wb_sel_i[0]
                && wb_dat_i[BIT_LINK_CTRL_ENABLE];
        end
    end

    // mode, loopback and self rx settings
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            mode_q <= MATCH_MODE_RESET;
            loopback_q <= 1'b0;
            self_rx_q <= 1'b0;
        end
        else if (wr_c && wb_sel_i[0])
        begin
            if (wb_adr_i == OFF_RECEIVE_MODE)
            begin
                mode_q <= wb_dat_i[1:0];
            end
            if (wb_adr_i == OFF_TRANSMIT_MODE)
            begin
                loopback_q <= wb_dat_i[BIT_LOOPBACK_CTL];
            end
            if (wb_adr_i == OFF_BUF_MGR_FOURTEEN)
            begin
                self_rx_q <= wb_dat_i[BIT_SELF_RX];
            end
        end
    end

    // node identifier and hash table, byte-lane writes
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            node_id_q <= 48'h0;
            hash_q <= 64'h0;
        end
        else if (wr_c)
        begin
            unique case (wb_adr_i)
                OFF_NODE_ID_LOW:
                begin
                    // only three lanes exist; the top lane is cut on purpose
                    node_id_q[23:0] <= 24'(lane_merge({8'h0, node_id_q[23:0]},
                        wb_dat_i, {1'b0, wb_sel_i[2:0]}));
                end
                OFF_NODE_ID_HIGH:
                begin
                    node_id_q[47:24] <= 24'(lane_merge({8'h0, node_id_q[47:24]},
                        wb_dat_i, {1'b0, wb_sel_i[2:0]}));
                end
                OFF_HASH_LOW:
                begin
                    hash_q[31:0] <= lane_merge(hash_q[31:0], wb_dat_i, wb_sel_i);
                end
                OFF_HASH_HIGH:
                begin
                    hash_q[63:32] <= lane_merge(hash_q[63:32], wb_dat_i, wb_sel_i);
                end
                default:
                begin
                    // other offsets hold nothing here
                end
            endcase
        end
    end

    // read data latched with the acknowledge; unmapped reads zero
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            rdata_q <= 32'h0;
        end
        else if (req_c && !wb_we_i)
        begin
            unique case (wb_adr_i)
                OFF_LINK_CONTROL_ONE: rdata_q <= {24'h0, ctl_q};
                OFF_RECEIVE_MODE: rdata_q <= {30'h0, mode_q};
                OFF_TRANSMIT_MODE: rdata_q <= {30'h0, loopback_q, 1'b0};
                OFF_BUF_MGR_FOURTEEN: rdata_q <= {31'h0, self_rx_q};
                OFF_NODE_ID_LOW: rdata_q <= {8'h0, node_id_q[23:0]};
                OFF_NODE_ID_HIGH: rdata_q <= {8'h0, node_id_q[47:24]};
                OFF_HASH_LOW: rdata_q <= hash_q[31:0];
                OFF_HASH_HIGH: rdata_q <= hash_q[63:32];
                OFF_FILTER_STATUS: rdata_q <= {30'h0, link_init, last_accept_q};
                default: rdata_q <= 32'h0;
            endcase
        end
    end

    // accept decision for the presented packet
    self_accept_decide u_decide (
        .match_mode(mode_q),
        .loopback_ctl(loopback_q),
        .self_rx(self_rx_q),
        .node_id(node_id_q),
        .hash_table(hash_q),
        .dest_addr(pkt_dest),
        .crc_index(pkt_crc_index),
        .accept(accept_c)
    );

    // registered verdict; nothing passes while the link is held initialised
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            accept_q <= 1'b0;
            drop_q <= 1'b0;
            last_accept_q <= 1'b0;
        end
        else
        begin
            // verdict from mode, loopback, self rx
            accept_q <= pkt_valid && !ctl_q[BIT_LINK_CTRL_ENABLE] && accept_c;
            drop_q <= pkt_valid && !(!ctl_q[BIT_LINK_CTRL_ENABLE] && accept_c);
            if (pkt_valid)
            begin
                last_accept_q <= !ctl_q[BIT_LINK_CTRL_ENABLE] && accept_c;
            end
        end
    end

    // sram cycle length from select bit
    assign sram_len_c = ctl_q[BIT_SRAM_CYCLE_SELECT] ? SRAM_FAST_CNT : SRAM_SLOW_CNT;

    // sram slot strobe, one pulse per sram cycle
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || ctl_q[BIT_LINK_CTRL_ENABLE])
        begin
            sram_cnt_q <= '0;
            slot_q <= 1'b0;
        end
        else if (sram_cnt_q >= sram_len_c - SRAM_CNT_W'(1))
        begin
            sram_cnt_q <= '0;
            slot_q <= 1'b1;
        end
        else
        begin
            sram_cnt_q <= sram_cnt_q + SRAM_CNT_W'(1);
            slot_q <= 1'b0;
        end
    end

    // outputs
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign pkt_accept = accept_q;
    assign pkt_drop = drop_q;
    assign link_init = ctl_q[BIT_LINK_CTRL_ENABLE];
    assign buf_reset = buf_reset_q;
    assign loopback_mode = loopback_q;
    assign tx_suppress = loopback_q;
    assign host_bus_width = ctl_q[BIT_HOST_BUS_WIDTH];
    assign match_mode = mode_q;
    assign sram_cycle_len = sram_len_c;
    assign sram_slot = slot_q;

    // checks
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    property p_bus_ack;
        @(posedge sys_clk) disable iff (!resetn) s_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("bus ack timing wrong");
    property p_self_drop;
        @(posedge sys_clk) disable iff (!resetn)
        pkt_valid && mode_q == MODE_ALL && loopback_q && self_rx_q |=> pkt_drop && !pkt_accept;
    endproperty
    a_self_drop: assert property (p_self_drop) else $error("self packet not dropped");
    property p_mode_off;
        @(posedge sys_clk) disable iff (!resetn)
        pkt_valid && mode_q == MODE_OFF |=> !pkt_accept && pkt_drop;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("mode off accepted");
    property p_lower_id;
        @(posedge sys_clk) disable iff (!resetn)
        pkt_valid && !link_init && mode_q == MODE_LOWER_ID && !loopback_q && pkt_dest[40]
        && node_id_q[40] && pkt_dest[23:0] == node_id_q[23:0] |=> pkt_accept;
    endproperty
    a_lower_id: assert property (p_lower_id) else $error("lower id lost");
    property p_hash;
        @(posedge sys_clk) disable iff (!resetn)
        pkt_valid && !link_init && mode_q == MODE_HASH && !loopback_q && pkt_dest[40]
        && node_id_q[40] && hash_q[pkt_crc_index] |=> pkt_accept;
    endproperty
    a_hash: assert property (p_hash) else $error("hash hit lost");
    property p_init_write;
        @(posedge sys_clk) disable iff (!resetn)
        wr_c && wb_adr_i == OFF_LINK_CONTROL_ONE && wb_sel_i[0] && wb_dat_i[7]
        |=> buf_reset && link_init;
    endproperty
    a_init_write: assert property (p_init_write) else $error("init write no effect");
    property p_sram_len;
        @(posedge sys_clk) disable iff (!resetn)
        sram_cycle_len == (ctl_q[6] ? 3'd4 : 3'd6);
    endproperty
    a_sram_len: assert property (p_sram_len) else $error("sram cycle length wrong");
    property p_bus_width;
        @(posedge sys_clk) disable iff (!resetn)
        wr_c && wb_adr_i == OFF_LINK_CONTROL_ONE && wb_sel_i[0]
        |=> host_bus_width == $past(wb_dat_i[5]);
    endproperty
    a_bus_width: assert property (p_bus_width) else $error("bus width not written");
    property p_loopback;
        @(posedge sys_clk) disable iff (!resetn)
        loopback_mode |-> (tx_suppress and (pkt_valid && mode_q == MODE_HASH && !pkt_dest[40]
        && pkt_dest != node_id_q |=> !pkt_accept));
    endproperty
    a_loopback: assert property (p_loopback) else $error("loopback not honoured");
    property p_mode_write;
        @(posedge sys_clk) disable iff (!resetn)
        wr_c && wb_adr_i == OFF_RECEIVE_MODE && wb_sel_i[0] |=> match_mode == $past(wb_dat_i[1:0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode not written");
    property p_reset_val;
        @(posedge sys_clk) $past(!resetn) |-> ctl_q == 8'hB6 && link_init;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("control reset value wrong");
endmodule : self_filter_ctl

// ==== rtl/self_filter_pkg.sv ====
// shared offsets, field positions, reset values and timing for the self filter block
package self_filter_pkg;
    // register byte offsets on the wishbone bus
    localparam logic [7:0] OFF_LINK_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFF_RECEIVE_MODE = 8'h04;
    localparam logic [7:0] OFF_TRANSMIT_MODE = 8'h08;
    localparam logic [7:0] OFF_BUF_MGR_FOURTEEN = 8'h0C;
    localparam logic [7:0] OFF_NODE_ID_LOW = 8'h10;
    localparam logic [7:0] OFF_NODE_ID_HIGH = 8'h14;
    localparam logic [7:0] OFF_HASH_LOW = 8'h18;
    localparam logic [7:0] OFF_HASH_HIGH = 8'h1C;
    localparam logic [7:0] OFF_FILTER_STATUS = 8'h20;
    // link_control_one field positions
    localparam int BIT_LINK_CTRL_ENABLE = 7;
    localparam int BIT_SRAM_CYCLE_SELECT = 6;
    localparam int BIT_HOST_BUS_WIDTH = 5;
    localparam int BIT_BUFFER_BUS_WIDTH = 4;
    // other control field positions
    localparam int BIT_LOOPBACK_CTL = 1;
    localparam int BIT_SELF_RX = 0;
    localparam int BIT_NODE_GROUP = 40;
    // values after reset
    localparam logic [7:0] LINK_CONTROL_ONE_RESET = 8'hB6;
    localparam logic [1:0] MATCH_MODE_RESET = 2'h1;
    // address match modes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_LOWER_ID = 2'h1;
    localparam logic [1:0] MODE_HASH = 2'h2;
    localparam logic [1:0] MODE_ALL = 2'h3;
    // timing: clock period and sram cycle times in ns
    localparam int CLK_PERIOD_NS = 25;
    localparam int SRAM_FAST_NS = 100;
    localparam int SRAM_SLOW_NS = 150;
    localparam int SRAM_FAST_CYCLES = (SRAM_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SRAM_SLOW_CYCLES = (SRAM_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SRAM_CNT_W = 3;
    localparam logic [SRAM_CNT_W-1:0] SRAM_FAST_CNT = SRAM_CNT_W'(SRAM_FAST_CYCLES);
    localparam logic [SRAM_CNT_W-1:0] SRAM_SLOW_CNT = SRAM_CNT_W'(SRAM_SLOW_CYCLES);
endpackage : self_filter_pkg

// ==== rtl/self_accept_decide.sv ====
// classifies a self-sent packet and decides whether the filter accepts it
`timescale 1ns/1ps
module self_accept_decide
    import self_filter_pkg::*;
(
    // filter settings
    input wire logic [1:0] match_mode,
    input wire logic loopback_ctl,
    input wire logic self_rx,
    input wire logic [47:0] node_id,
    input wire logic [63:0] hash_table,
    // packet under test
    input wire logic [47:0] dest_addr,
    input wire logic [5:0] crc_index,
    // decision
    output logic accept
);
    // packet classes
    logic is_group;
    logic is_bcast;
    logic id_match;
    logic lower_match;
    logic hash_match;

    // class decode; group bit is the low bit of the first octet
    always_comb
    begin
        is_group = dest_addr[BIT_NODE_GROUP];
        is_bcast = &dest_addr;
        id_match = !is_group && (dest_addr == node_id);
        lower_match = is_group && !is_bcast && node_id[BIT_NODE_GROUP]
            && (dest_addr[23:0] == node_id[23:0]);
        hash_match = is_group && !is_bcast && node_id[BIT_NODE_GROUP]
            && hash_table[crc_index];
    end

    always_comb
    begin
        accept = 1'b0;
        unique case (match_mode)
            MODE_OFF:
            begin
                accept = 1'b0;
            end
            MODE_LOWER_ID:
            begin
                // loopback leaves only id match
                accept = id_match || (!loopback_ctl && (is_bcast || lower_match));
            end
            MODE_HASH:
            begin
                accept = id_match || (!loopback_ctl && (is_bcast || hash_match));
            end
            MODE_ALL:
            begin
                // loopback with self rx drops all
                accept = !(loopback_ctl && self_rx);
            end
        endcase
    end
endmodule : self_accept_decide

// ==== dv/self_pkt_model.sv ====
// far-side model: self-sent packet source and sram slot observer
`timescale 1ns/1ps
module self_pkt_model
(
    // clock
    input wire logic sys_clk,
    // packet path into the filter
    output logic pkt_valid,
    output logic [47:0] pkt_dest,
    output logic [5:0] pkt_crc_index,
    input wire logic pkt_accept,
    input wire logic pkt_drop,
    // sram slot timing
    input wire logic sram_slot,
    output logic [7:0] slot_gap
);
    logic [7:0] slot_cnt_q; // cycles since the last slot
    initial
    begin
        pkt_valid = 1'b0;
        pkt_dest = 48'h0;
        pkt_crc_index = 6'h0;
    end
    // memory here meets 80 ns access, so we only measure slot spacing
    always @(posedge sys_clk)
    begin
        if (sram_slot === 1'b1)
        begin
            slot_gap <= slot_cnt_q + 8'h01;
            slot_cnt_q <= 8'h00;
        end
        else
        begin
            slot_cnt_q <= slot_cnt_q + 8'h01;
        end
    end
    // one packet; lines show the inverse once the frame is gone
    task automatic send(input logic [47:0] dest, input logic [5:0] idx, output logic [1:0] res);
        @(posedge sys_clk);
        pkt_valid <= 1'b1;
        pkt_dest <= dest;
        pkt_crc_index <= idx;
        @(posedge sys_clk);
        pkt_valid <= 1'b0;
        pkt_dest <= ~dest;
        pkt_crc_index <= ~idx;
        #1;
        res = {pkt_accept, pkt_drop};
    endtask : send
endmodule : self_pkt_model

// ==== dv/self_packet_filter_and_control_one_tb.sv ====
// testbench for the self packet filter and first link control register
`timescale 1ns/1ps
module self_packet_filter_and_control_one_tb;
    import self_filter_pkg::*;
    logic sys_clk, resetn, cyc, stb, we, link_init, buf_reset, loopback_mode, tx_suppress;
    logic host_bus_width, pkt_valid, pkt_accept, pkt_drop, sram_slot, wb_ack_o;
    logic [7:0] adr, slot_gap;
    logic [31:0] dat, wb_dat_o, q;
    logic [47:0] pkt_dest;
    logic [5:0] pkt_crc_index;
    logic [1:0] match_mode, res;
    logic [2:0] sram_cycle_len;
    int fail_count, checks, resets, base;
    // rows: mode, loopback, self rx, accepted classes
    logic [8:0] rows [0:7] = '{9'h000, 9'h08D, 9'h0C1, 9'h115, 9'h141, 9'h1BF, 9'h1DF, 9'h1E0};
    // classes: id match, id miss, broadcast, lower id, hash
    logic [47:0] dst [0:4] = '{48'h020000334455, 48'h020000334456, 48'hFFFFFFFFFFFF,
        48'h010000334455, 48'h010000778899};
    logic [23:0] hi [0:4] = '{24'h020000, 24'h020000, 24'h020000, 24'h030000, 24'h030000};
    logic [5:0] idx [0:4] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h05};
    self_filter_ctl u_self_filter_ctl (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pkt_valid(pkt_valid), .pkt_dest(pkt_dest),
        .pkt_crc_index(pkt_crc_index), .pkt_accept(pkt_accept), .pkt_drop(pkt_drop),
        .link_init(link_init), .buf_reset(buf_reset), .loopback_mode(loopback_mode),
        .tx_suppress(tx_suppress), .host_bus_width(host_bus_width), .match_mode(match_mode),
        .sram_cycle_len(sram_cycle_len), .sram_slot(sram_slot));
    self_pkt_model u_self_pkt_model (.sys_clk(sys_clk), .pkt_valid(pkt_valid),
        .pkt_dest(pkt_dest), .pkt_crc_index(pkt_crc_index), .pkt_accept(pkt_accept),
        .pkt_drop(pkt_drop), .sram_slot(sram_slot), .slot_gap(slot_gap));
    // 40 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // count buffer reset pulses, one per high cycle
    always @(posedge sys_clk)
    begin
        if (buf_reset === 1'b1)
            resets <= resets + 1;
    end
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // counts and verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // one classic wishbone cycle, held until ack
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
        begin
            fail_count++;
            stop_test();
        end
    endtask : wb_xfer
    // main sequence
    initial
    begin
        {resetn, cyc, stb, we} = 4'h0;
        adr = 8'h00;
        dat = 32'h0;
        fail_count = 0;
        checks = 0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        wb_xfer(1'b0, OFF_LINK_CONTROL_ONE, 32'h0);
        chk(q, 32'h000000B6);
        chk({link_init, host_bus_width, sram_cycle_len}, {2'h3, 3'h6});
        wb_xfer(1'b0, OFF_RECEIVE_MODE, 32'h0);
        chk(q, 32'h00000001);
        wb_xfer(1'b0, 8'h24, 32'h0);
        chk(q, 32'h00000000);
        u_self_pkt_model.send(dst[2], 6'h00, res);
        chk(res, 2'h1);
        $display("test reset done");
        wb_xfer(1'b1, OFF_LINK_CONTROL_ONE, 32'h00000006);
        wb_xfer(1'b0, OFF_LINK_CONTROL_ONE, 32'h0);
        chk(q, 32'h00000016);
        chk({link_init, host_bus_width, sram_cycle_len}, {2'h0, 3'h6});
        wb_xfer(1'b1, OFF_LINK_CONTROL_ONE, 32'h00000076);
        wb_xfer(1'b0, OFF_LINK_CONTROL_ONE, 32'h0);
        chk(q, 32'h00000076);
        chk({host_bus_width, sram_cycle_len}, {1'b1, 3'h4});
        repeat (12) @(posedge sys_clk);
        chk(slot_gap, 8'h04);
        $display("test control done");
        wb_xfer(1'b1, OFF_NODE_ID_LOW, 32'h00334455);
        wb_xfer(1'b1, OFF_HASH_LOW, 32'h00000020);
        wb_xfer(1'b1, OFF_HASH_HIGH, 32'h0);
        for (int r = 0; r < 8; r++)
        begin
            wb_xfer(1'b1, OFF_RECEIVE_MODE, {30'h0, rows[r][8:7]});
            wb_xfer(1'b1, OFF_TRANSMIT_MODE, {30'h0, rows[r][6], 1'b0});
            wb_xfer(1'b1, OFF_BUF_MGR_FOURTEEN, {31'h0, rows[r][5]});
            chk({loopback_mode, tx_suppress, match_mode}, {rows[r][6], rows[r][6], rows[r][8:7]});
            for (int c = 0; c < 5; c++)
            begin
                wb_xfer(1'b1, OFF_NODE_ID_HIGH, {8'h00, hi[c]});
                u_self_pkt_model.send(dst[c], idx[c], res);
                chk(res, rows[r][c] ? 2'h2 : 2'h1);
            end
        end
        $display("test filter done");
        wb_xfer(1'b1, OFF_TRANSMIT_MODE, 32'h0);
        base = resets;
        wb_xfer(1'b1, OFF_LINK_CONTROL_ONE, 32'h000000F6);
        repeat (2) @(posedge sys_clk);
        chk(resets - base, 32'h1);
        chk(link_init, 1'b1);
        u_self_pkt_model.send(dst[2], 6'h00, res);
        chk(res, 2'h1);
        wb_xfer(1'b0, OFF_FILTER_STATUS, 32'h0);
        chk(q, 32'h00000002);
        $display("test init done");
        stop_test();
    end
endmodule : self_packet_filter_and_control_one_tb
